//--- oipd_int_disable.v
// Purpose: Per-source interrupt enable with write-one-to-disable control
// Assumes: Strobes and events come from logic on sys_clk_i
// Notes: Disable wins over a same-cycle enable of the same bit
`timescale 1ns/1ps
`default_nettype none
`include "oipd_defines.vh"

module oipd_int_disable (
  // Clock and reset
  input wire sys_clk_i,
  input wire sys_rst_i,
  // Enable write, one bits set enables
  input wire en_wr_i,
  input wire [`OIPD_MSB:0] en_data_i,
  // Disable write, one bits clear enables
  input wire dis_wr_i,
  input wire [`OIPD_MSB:0] dis_data_i,
  // Status write, one bits clear flags
  input wire sts_wr_i,
  input wire [`OIPD_MSB:0] sts_data_i,
  // Event pulses from the controller
  input wire [`OIPD_MSB:0] evt_i,
  // State and interrupt
  output reg [`OIPD_MSB:0] int_enable_o,
  output reg [`OIPD_MSB:0] int_status_o,
  output reg [`OIPD_MSB:0] int_pending_o,
  output reg [`OIPD_MSB:0] evt_masked_o,
  output reg [`OIPD_MSB:0] disable_hit_o,
  output reg irq_o
);

  // ====================================================================
  // Helpers
  // Per-bit write-one effect: only ones act, zeros leave the bit alone
  function upd_bit;
    input cur;
    input set_wr;
    input set_bit;
    input off_wr;
    input off_bit;
    begin
      if (off_wr && off_bit) begin
        upd_bit = 1'b0;
      end else if (set_wr && set_bit) begin
        upd_bit = 1'b1;
      end else begin
        upd_bit = cur;
      end
    end
  endfunction

  // ====================================================================
  // Declarations
  reg [`OIPD_MSB:0] enable;
  reg [`OIPD_MSB:0] next_enable;
  wire [`OIPD_MSB:0] status;
  wire [`OIPD_MSB:0] pending;

  // ====================================================================
  // Enable register update
  always @* begin
    next_enable = enable;
    next_enable[`OIPD_FRAME_OVERFLOW_INT_OFF] = upd_bit(enable[`OIPD_FRAME_OVERFLOW_INT_OFF],
      en_wr_i, en_data_i[`OIPD_FRAME_OVERFLOW_INT_OFF],
      dis_wr_i, dis_data_i[`OIPD_FRAME_OVERFLOW_INT_OFF]);
    next_enable[`OIPD_FATAL_ERROR_INT_OFF] = upd_bit(enable[`OIPD_FATAL_ERROR_INT_OFF],
      en_wr_i, en_data_i[`OIPD_FATAL_ERROR_INT_OFF],
      dis_wr_i, dis_data_i[`OIPD_FATAL_ERROR_INT_OFF]);
    next_enable[`OIPD_RESUME_INT_OFF] = upd_bit(enable[`OIPD_RESUME_INT_OFF],
      en_wr_i, en_data_i[`OIPD_RESUME_INT_OFF],
      dis_wr_i, dis_data_i[`OIPD_RESUME_INT_OFF]);
    next_enable[`OIPD_FRAME_BEGIN_INT_OFF] = upd_bit(enable[`OIPD_FRAME_BEGIN_INT_OFF],
      en_wr_i, en_data_i[`OIPD_FRAME_BEGIN_INT_OFF],
      dis_wr_i, dis_data_i[`OIPD_FRAME_BEGIN_INT_OFF]);
    next_enable[`OIPD_DONE_QUEUE_WRITEBACK_INT_OFF] = upd_bit(enable[`OIPD_DONE_QUEUE_WRITEBACK_INT_OFF],
      en_wr_i, en_data_i[`OIPD_DONE_QUEUE_WRITEBACK_INT_OFF],
      dis_wr_i, dis_data_i[`OIPD_DONE_QUEUE_WRITEBACK_INT_OFF]);
    next_enable[`OIPD_ROOT_HUB_CHANGE_INT_OFF] = upd_bit(enable[`OIPD_ROOT_HUB_CHANGE_INT_OFF],
      en_wr_i, en_data_i[`OIPD_ROOT_HUB_CHANGE_INT_OFF],
      dis_wr_i, dis_data_i[`OIPD_ROOT_HUB_CHANGE_INT_OFF]);
    next_enable[`OIPD_SCHED_OVERRUN_INT_OFF] = upd_bit(enable[`OIPD_SCHED_OVERRUN_INT_OFF],
      en_wr_i, en_data_i[`OIPD_SCHED_OVERRUN_INT_OFF],
      dis_wr_i, dis_data_i[`OIPD_SCHED_OVERRUN_INT_OFF]);
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      enable <= `OIPD_ENABLE_RST;
    end else begin
      enable <= next_enable;
    end
  end

  // ====================================================================
  // Event flags
  // Flags keep recording while disabled, so re-enabling shows old events
  oipd_sticky_bank u_flags (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(evt_i),
    .clr_wr_i(sts_wr_i),
    .clr_data_i(sts_data_i),
    .flag_o(status)
  );

  // ====================================================================
  // Gating
  // Disabled sources never reach the interrupt line
  assign pending = status & enable;

  // ====================================================================
  // Registered outputs
  // One cycle of latency is traded for flop-driven outputs
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      int_enable_o <= `OIPD_ENABLE_RST;
      int_status_o <= `OIPD_STATUS_RST;
      int_pending_o <= `OIPD_STATUS_RST;
      evt_masked_o <= `OIPD_STATUS_RST;
      disable_hit_o <= `OIPD_STATUS_RST;
      irq_o <= 1'b0;
    end else begin
      int_enable_o <= enable;
      int_status_o <= status;
      int_pending_o <= pending;
      evt_masked_o <= evt_i & enable;
      disable_hit_o <= enable & ~next_enable;
      irq_o <= |pending;
    end
  end

endmodule // oipd_int_disable
`default_nettype wire

//--- oipd_defines.vh
// Purpose: Constants for the interrupt-disable control of the host controller
// Assumes: One clock, synchronous active-high reset, same-domain control strobes
// Notes: Bit positions follow the disable register layout; bits above 6 absent
//
// Functional notes
// - Writing one to bit 5 stops frame-number-overflow interrupts; zero changes nothing.
// - Writing one to bit 4 stops unrecoverable-error interrupts; zero changes nothing.
// - Writing one to bit 3 stops resume-detect interrupts; zero changes nothing.
// - Writing one to bit 2 stops start-of-frame interrupts; zero changes nothing.
// - Writing one to bit 1 stops done-queue write-back interrupts; zero changes nothing.
// - Writing one to bit 6 stops root-hub status-change interrupts; zero changes nothing.
`ifndef OIPD_DEFINES_VH
`define OIPD_DEFINES_VH

// ====================================================================
// Field layout
`define OIPD_NUM_SRC 7
`define OIPD_MSB 6
`define OIPD_SCHED_OVERRUN_INT_OFF 0
`define OIPD_DONE_QUEUE_WRITEBACK_INT_OFF 1
`define OIPD_FRAME_BEGIN_INT_OFF 2
`define OIPD_RESUME_INT_OFF 3
`define OIPD_FATAL_ERROR_INT_OFF 4
`define OIPD_FRAME_OVERFLOW_INT_OFF 5
`define OIPD_ROOT_HUB_CHANGE_INT_OFF 6

// ====================================================================
// Reset values
`define OIPD_ENABLE_RST 7'h00
`define OIPD_STATUS_RST 7'h00

`endif

//--- oipd_sticky_bank.v
// Purpose: Sticky event flags with write-one-to-clear
// Assumes: Event and clear inputs are on the same clock
// Notes: A set in the cycle of its clear wins
`timescale 1ns/1ps
`default_nettype none
`include "oipd_defines.vh"

module oipd_sticky_bank (
  // Clock and reset
  input wire sys_clk_i,
  input wire sys_rst_i,
  // Events and clears
  input wire [`OIPD_MSB:0] set_i,
  input wire clr_wr_i,
  input wire [`OIPD_MSB:0] clr_data_i,
  // Flags
  output reg [`OIPD_MSB:0] flag_o
);

  // ====================================================================
  // Flags
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      flag_o <= `OIPD_STATUS_RST;
    end else if (clr_wr_i) begin
      // Set beats clear so an event in the clear cycle is not lost
      flag_o <= (flag_o & ~clr_data_i) | set_i;
    end else begin
      flag_o <= flag_o | set_i;
    end
  end

endmodule // oipd_sticky_bank
`default_nettype wire

//--- oipd_chk_assertions.sv
// Purpose: Port assertions for the interrupt disable block
// Assumes: One clock, synchronous reset active high
// Notes: The enable copy lags a strobe by two edges
`timescale 1ns/1ps
`default_nettype none
module oipd_chk (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Watched ports
  input wire logic dis_wr_i,
  input wire logic [6:0] dis_data_i,
  input wire logic [6:0] evt_i,
  input wire logic [6:0] int_enable_o,
  input wire logic [6:0] int_status_o,
  input wire logic [6:0] int_pending_o,
  input wire logic [6:0] evt_masked_o,
  input wire logic [6:0] disable_hit_o,
  input wire logic irq_o
);
  // ==========
  // Properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence evt_aged; (evt_i != 7'h00) ##2 1'h1; endsequence
  a_dis_clears_en: assert property (dis_wr_i |-> ##2 (int_enable_o & $past(dis_data_i, 2)) == 7'h00)
    else $error("enable kept after disable");
  a_zero_keeps_en: assert property ((($past(int_enable_o) & ~int_enable_o)
    & ~($past(dis_data_i, 2) & {7{$past(dis_wr_i, 2)}})) == 7'h00) else $error("enable lost without disable");
  a_hit_is_drop: assert property ($past(disable_hit_o) == ($past(int_enable_o) & ~int_enable_o))
    else $error("hit pulse wrong");
  a_evt_masked: assert property (evt_masked_o == ($past(evt_i) & int_enable_o))
    else $error("masked event wrong");
  a_evt_sticks: assert property (evt_aged |-> (int_status_o & $past(evt_i, 2)) == $past(evt_i, 2))
    else $error("status flag not set");
  a_pend_in_sts: assert property ((int_pending_o & ~int_status_o) == 7'h00)
    else $error("pending without status");
  a_irq_level: assert property (irq_o == (int_pending_o != 7'h00))
    else $error("irq level wrong");
endmodule // oipd_chk
`default_nettype wire

//--- oipd_int_disable_tb.sv
// Purpose: Self-checking bench for the interrupt disable block
// Assumes: A strobe set after one edge is taken at the next
// Notes: Corner cases and reset follow the row loop
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) checks_done++; if ((a) !== (e)) begin fails++; $display("[ERR] %0t %h %h", $time, a, e); end
module oipd_int_disable_tb;
  logic sys_clk_i = 1'h0, sys_rst_i = 1'h1, en_wr_i, dis_wr_i, sts_wr_i, irq_o;
  logic [6:0] en_data_i, dis_data_i, sts_data_i, evt_i, int_enable_o, int_status_o, int_pending_o;
  logic [6:0] evt_masked_o, disable_hit_o;
  logic [13:0] rows [8] = '{{7'h00, 7'h7f}, {7'h01, 7'h7e}, {7'h02, 7'h7d}, {7'h04, 7'h7b}, {7'h08, 7'h77},
    {7'h10, 7'h6f}, {7'h20, 7'h5f}, {7'h40, 7'h3f}};
  int fails = 0;
  int checks_done = 0;
  oipd_int_disable DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .en_wr_i(en_wr_i), .en_data_i(en_data_i),
    .dis_wr_i(dis_wr_i), .dis_data_i(dis_data_i), .sts_wr_i(sts_wr_i), .sts_data_i(sts_data_i), .evt_i(evt_i),
    .int_enable_o(int_enable_o), .int_status_o(int_status_o), .int_pending_o(int_pending_o),
    .evt_masked_o(evt_masked_o), .disable_hit_o(disable_hit_o), .irq_o(irq_o));
  task drive(input logic [30:0] v);
    @(posedge sys_clk_i);
    {en_wr_i, en_data_i, dis_wr_i, dis_data_i, sts_wr_i, sts_data_i, evt_i} <= v;
  endtask
  task give_verdict;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial forever #50 sys_clk_i = ~sys_clk_i;
  // Run is near 75 cycles, so 1000 means a hang
  initial begin
    #100000;
    fails++;
    give_verdict;
  end
  initial begin
    {en_wr_i, en_data_i, dis_wr_i, dis_data_i, sts_wr_i, sts_data_i, evt_i} = 31'h0;
    repeat (10) @(posedge sys_clk_i);
    sys_rst_i <= 1'h0;
    foreach (rows[i]) begin
      drive({1'h1, 7'h7f, 1'h0, 7'h00, 1'h1, 7'h7f, 7'h00});
      drive({9'h001, rows[i][13:7], 15'h0000});
      drive(31'h0);
      #1;
      `CHK(disable_hit_o, ~rows[i][6:0])
      drive(31'h0);
      #1;
      `CHK(int_enable_o, rows[i][6:0])
      drive(31'h7f);
      drive(31'h0);
      #1;
      `CHK(evt_masked_o, rows[i][6:0])
      drive(31'h0);
      #1;
      `CHK(int_pending_o, rows[i][6:0])
    end
    // Disable beats a same-cycle enable, then a back-to-back disable
    drive({1'h1, 7'h48, 1'h1, 7'h09, 1'h1, 7'h7f, 7'h00});
    drive({9'h001, 7'h10, 15'h0000});
    drive(31'h01);
    drive(31'h0);
    drive(31'h0);
    #1;
    `CHK(int_enable_o, 7'h66)
    `CHK(int_status_o, 7'h01)
    `CHK(irq_o, 1'h0)
    sys_rst_i <= 1'h1;
    drive(31'h0);
    drive(31'h0);
    sys_rst_i <= 1'h0;
    #1;
    `CHK({int_enable_o, int_status_o}, 14'h0000)
    give_verdict;
  end
endmodule // oipd_int_disable_tb
bind oipd_int_disable oipd_chk u_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .dis_wr_i(dis_wr_i),
  .dis_data_i(dis_data_i), .evt_i(evt_i), .int_enable_o(int_enable_o), .int_status_o(int_status_o),
  .int_pending_o(int_pending_o), .evt_masked_o(evt_masked_o), .disable_hit_o(disable_hit_o), .irq_o(irq_o));
`default_nettype wire
